// ### scs_ctrl.sv
// system clock switch controller with apb registers
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "scs_defs.svh"
module scs_ctrl
   import scs_pkg::*;
(
   input wire logic clock, // 125 mhz system clock
   input wire logic resetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [3:0] pstrb, // apb byte strobes
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic clock_switch_monitor_cfg, // 0 enables switching
   input wire logic [2:0] reset_source_cfg, // source after reset
   input wire logic [1:0] primary_submode_cfg, // fixed primary submode
   input wire logic watchdog_timer_en, // watchdog enabled
   input wire logic secondary_osc_enable, // keep secondary running
   input wire logic osc_startup_timer_done, // startup timer expired
   input wire logic pll_lock_in, // pll lock detect
   input wire logic clock_fail_in, // fail-safe monitor event
   input wire logic new_clk_in, // raw selected new clock
   output scs_osc_s osc_enable, // oscillator enables
   output logic [2:0] sys_clk_select, // mux select of system clock
   output logic [1:0] primary_submode, // submode to primary osc
   output logic irq // level interrupt
);
   // ****************************************************************
   // state and registers
   // ****************************************************************
   typedef enum logic [2:0] {
      SCS_IDLE = 3'b000,
      SCS_CHECK = 3'b001,
      SCS_WAIT_RDY = 3'b010,
      SCS_SETTLE = 3'b011,
      SCS_SWITCH = 3'b100
   } scs_state_e;

   scs_state_e state_reg;
   logic [2:0] cur_reg;
   logic [2:0] new_reg;
   logic req_reg;
   logic lock_reg;
   logic fail_reg;
   logic [1:0] key_st_reg;
   logic [3:0] win_reg;
   logic [2:0] old_reg;
   logic [`SCS_IRQ_BITS-1:0] stat_reg;
   logic [`SCS_IRQ_BITS-1:0] mask_reg;
   logic [1:0] sub_reg;
   logic en_reg;
   logic start_pulse;
   logic settle_done;
   logic nclk_s1, nclk_s2, nclk_s3, lock_s1, lock_s2, tmr_s1, tmr_s2;
   logic fail_s1, fail_s2;
   logic wr, rd, win_open, done_ev, abort_ev;
   logic [31:0] osc_word;
   scs_osc_s need_cur, need_new;

   // true when a source runs from the pll
   function automatic logic uses_pll(input logic [2:0] s);
      return (s == SCS_SRC_FAST_PLL) || (s == SCS_SRC_PRI_PLL);
   endfunction

   // true when a source needs the crystal startup timer
   function automatic logic uses_xtal(input logic [2:0] s);
      return (s == SCS_SRC_PRI) || (s == SCS_SRC_PRI_PLL) ||
         (s == SCS_SRC_SEC);
   endfunction

   // oscillator enables needed to run one source
   function automatic scs_osc_s need(input logic [2:0] s);
      scs_osc_s o;
      o = '0;
      o.pll = uses_pll(s);
      o.primary_oscillator = (s == SCS_SRC_PRI) || (s == SCS_SRC_PRI_PLL);
      o.secondary_oscillator = (s == SCS_SRC_SEC);
      o.low_power_rc = (s == SCS_SRC_LOW_PWR);
      o.fast_internal_rc = (s == SCS_SRC_FAST) || (s == SCS_SRC_FAST_PLL) ||
         (s == SCS_SRC_FAST_DIV);
      return o;
   endfunction

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   // zero-wait slave; unmapped addresses read zero, no error
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign win_open = (win_reg != 4'h0);
   assign osc_word = {17'h0, cur_reg, 1'b0, new_reg, 2'b00, lock_reg,
      1'b0, fail_reg, 2'b00, req_reg};
   // function results held as nets so single fields can be picked
   assign need_cur = need(cur_reg);
   assign need_new = need(new_reg);

   // ****************************************************************
   // synchronisers for asynchronous inputs
   // ****************************************************************
   // crystal and pll status come from analog domains
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         {nclk_s1, nclk_s2, nclk_s3} <= 3'b000;
         {lock_s1, lock_s2, tmr_s1, tmr_s2} <= 4'h0;
         {fail_s1, fail_s2} <= 2'b00;
      end else begin
         nclk_s1 <= new_clk_in;
         nclk_s2 <= nclk_s1;
         nclk_s3 <= nclk_s2;
         lock_s1 <= pll_lock_in;
         lock_s2 <= lock_s1;
         tmr_s1 <= osc_startup_timer_done;
         tmr_s2 <= tmr_s1;
         fail_s1 <= clock_fail_in;
         fail_s2 <= fail_s1;
      end
   end

   // ****************************************************************
   // configuration capture
   // ****************************************************************
   // straps are sampled by a clocked process after reset release
   logic cfg_taken_reg;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cfg_taken_reg <= 1'b0;
         en_reg <= 1'b0;
         sub_reg <= 2'b00;
      end else if (!cfg_taken_reg) begin
         cfg_taken_reg <= 1'b1;
         en_reg <= !clock_switch_monitor_cfg;
         sub_reg <= primary_submode_cfg;
      end
   end
   assign primary_submode = sub_reg; // never changed by switching

   // ****************************************************************
   // unlock sequence
   // ****************************************************************
   // key writes open a short window; one protected byte write closes it
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         key_st_reg <= 2'b00;
         win_reg <= 4'h0;
      end else if (wr && paddr == `SCS_ADDR_KEY && pstrb[0]) begin
         if (pwdata[7:0] == `SCS_KEY1) begin
            key_st_reg <= 2'b01;
         end else if (pwdata[7:0] == `SCS_KEY2 && key_st_reg == 2'b01) begin
            key_st_reg <= 2'b00;
            win_reg <= `SCS_WIN_CYC;
         end else begin
            key_st_reg <= 2'b00;
         end
      end else if (wr && paddr == `SCS_ADDR_OSC) begin
         win_reg <= 4'h0; // window used up
      end else if (win_open) begin
         win_reg <= win_reg - 4'h1;
      end
   end

   // ****************************************************************
   // osc_control_reg fields and switch sequence
   // ****************************************************************
   // new-source select, byte 1, only inside window
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         new_reg <= 3'b000;
      end else if (wr && paddr == `SCS_ADDR_OSC && pstrb[1] && win_open &&
                   en_reg && state_reg == SCS_IDLE) begin
         new_reg <= pwdata[`SCS_NEW_LO +: 3]; // any of the sources
      end
   end

   // sequencer; cpu is never stalled while it runs
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg <= SCS_IDLE;
         req_reg <= 1'b0;
         cur_reg <= 3'b000;
         old_reg <= 3'b000;
      end else begin
         unique case (state_reg)
            SCS_IDLE: begin
               if (!cfg_taken_reg) begin
                  cur_reg <= reset_source_cfg;
                  old_reg <= reset_source_cfg;
               end else if (wr && paddr == `SCS_ADDR_OSC && pstrb[0] &&
                            win_open && en_reg &&
                            pwdata[`SCS_BIT_REQ]) begin
                  req_reg <= 1'b1; // ignored when disabled
                  state_reg <= SCS_CHECK;
               end
            end
            SCS_CHECK: begin
               if (new_reg == cur_reg) begin
                  req_reg <= 1'b0; // redundant request
                  state_reg <= SCS_IDLE;
               end else begin
                  old_reg <= cur_reg;
                  state_reg <= SCS_WAIT_RDY;
               end
            end
            SCS_WAIT_RDY: begin
               // software must route pll to pll via plain fast rc
               if ((!uses_pll(new_reg) || lock_s2) &&
                   (!uses_xtal(new_reg) || tmr_s2)) begin
                  state_reg <= SCS_SETTLE;
               end
            end
            SCS_SETTLE: begin
               if (settle_done) begin
                  state_reg <= SCS_SWITCH;
               end
            end
            SCS_SWITCH: begin
               cur_reg <= new_reg;
               req_reg <= 1'b0; // success
               state_reg <= SCS_IDLE;
            end
            default: state_reg <= SCS_IDLE;
         endcase
      end
   end

   assign start_pulse = (state_reg == SCS_WAIT_RDY) &&
      (!uses_pll(new_reg) || lock_s2) && (!uses_xtal(new_reg) || tmr_s2);

   // lock and fail flags; cleared when a valid switch begins
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         lock_reg <= 1'b0;
         fail_reg <= 1'b0;
      end else begin
         if (state_reg == SCS_CHECK && new_reg != cur_reg) begin
            lock_reg <= 1'b0;
         end else begin
            lock_reg <= lock_s2;
         end
         // a fail event in the clearing cycle still wins
         if (fail_s2 && en_reg) begin
            fail_reg <= 1'b1;
         end else if (state_reg == SCS_CHECK && new_reg != cur_reg) begin
            fail_reg <= 1'b0;
         end
      end
   end

   // settle counter runs on synchronised edges of the new clock
   scs_settle #(.CW(4)) u_settle (
      .clock(clock),
      .resetn(resetn),
      .start(start_pulse),
      .new_clk_tick(nclk_s2 && !nclk_s3),
      .target(`SCS_SETTLE_CYC),
      .done(settle_done)
   );

   // ****************************************************************
   // oscillator enables and clock select
   // ****************************************************************
   // old source drops after the switch, save kept ones
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         osc_enable <= '0;
         sys_clk_select <= 3'b000;
      end else begin
         osc_enable <= need_cur |
            ((state_reg != SCS_IDLE && state_reg != SCS_CHECK) ?
               need_new : '0);
         osc_enable.low_power_rc <= need_cur.low_power_rc ||
            watchdog_timer_en || en_reg ||
            (state_reg inside {SCS_WAIT_RDY, SCS_SETTLE, SCS_SWITCH} &&
             need_new.low_power_rc);
         osc_enable.secondary_oscillator <= need_cur.secondary_oscillator
            || secondary_osc_enable ||
            (state_reg inside {SCS_WAIT_RDY, SCS_SETTLE, SCS_SWITCH} &&
             need_new.secondary_oscillator);
         sys_clk_select <= cur_reg;
      end
   end

   // ****************************************************************
   // interrupts and apb read
   // ****************************************************************
   assign done_ev = (state_reg == SCS_SWITCH);
   assign abort_ev = (state_reg == SCS_CHECK) && (new_reg == cur_reg);

   // sticky status, write one to clear, set beats clear
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         stat_reg <= '0;
         mask_reg <= '0;
      end else begin
         if (wr && paddr == `SCS_ADDR_IRQ_MASK && pstrb[0]) begin
            mask_reg <= pwdata[`SCS_IRQ_BITS-1:0];
         end
         stat_reg <= (stat_reg & ~((wr && paddr == `SCS_ADDR_IRQ_STAT &&
            pstrb[0]) ? pwdata[`SCS_IRQ_BITS-1:0] : '0)) |
            {abort_ev, done_ev};
      end
   end
   assign irq = |(stat_reg & mask_reg);

   // read data registered in the setup cycle
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd) begin
         unique case (paddr)
            `SCS_ADDR_OSC: prdata <= osc_word;
            `SCS_ADDR_IRQ_STAT: prdata <= {30'h0, stat_reg};
            `SCS_ADDR_IRQ_MASK: prdata <= {30'h0, mask_reg};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule // scs_ctrl

// ### scs_ctrl_sva.sv
// concurrent checks on the clock switch controller ports
`timescale 1ns/1ps
module scs_ctrl_sva
   import scs_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic clock_switch_monitor_cfg, // switch strap
   input wire logic [1:0] primary_submode_cfg, // submode strap
   input wire logic [1:0] primary_submode, // submode out
   input wire logic watchdog_timer_en, // watchdog on
   input wire logic secondary_osc_enable, // keep secondary
   input wire logic osc_startup_timer_done, // startup done
   input wire logic pll_lock_in, // pll lock
   input wire logic new_clk_in, // raw new clock
   input wire scs_osc_s osc_enable, // oscillator enables
   input wire logic [2:0] sys_clk_select // clock mux select
);
   // ****
   // helpers
   // ****
   logic [2:0] up_cnt;
   logic [3:0] edge_cnt;
   logic nclk_q;
   // keeps the first edges after reset out of the submode, hold, settle and low-power checks
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) up_cnt <= 3'h0;
      else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
   end
   // raw edges lead synchronised ones, so a raw count is a safe floor
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         nclk_q <= 1'b0;
         edge_cnt <= 4'h0;
      end else begin
         nclk_q <= new_clk_in;
         if ($changed(sys_clk_select)) edge_cnt <= 4'h0;
         else if (new_clk_in && !nclk_q && edge_cnt != 4'hF)
            edge_cnt <= edge_cnt + 4'h1;
      end
   end
   // ****
   // checks
   // ****
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   a_submode_fixed: assert property (
      up_cnt == 3'h7 |-> primary_submode == primary_submode_cfg)
      else $error("primary submode differs from strap");
   a_disabled_hold: assert property (
      up_cnt == 3'h7 && clock_switch_monitor_cfg |-> $stable(sys_clk_select))
      else $error("clock moved while switching disabled");
   a_settle_count: assert property (
      up_cnt == 3'h7 && $changed(sys_clk_select) |-> edge_cnt >= 4'hA)
      else $error("switch before ten new-clock edges");
   a_startup_wait: assert property (
      $changed(sys_clk_select) && sys_clk_select == SCS_SRC_PRI
      |-> osc_startup_timer_done)
      else $error("crystal taken before startup timer");
   a_pll_wait: assert property (
      $changed(sys_clk_select) && sys_clk_select == SCS_SRC_PRI_PLL
      |-> pll_lock_in)
      else $error("pll source taken before lock");
   a_sec_started: assert property (
      $changed(sys_clk_select) && sys_clk_select == SCS_SRC_SEC
      |-> osc_enable.secondary_oscillator)
      else $error("secondary selected while stopped");
   a_low_power_kept: assert property (
      up_cnt == 3'h7 && watchdog_timer_en |-> osc_enable.low_power_rc)
      else $error("low-power rc off with watchdog on");
   a_sec_kept: assert property (
      $past(osc_enable.secondary_oscillator) && secondary_osc_enable
      |-> osc_enable.secondary_oscillator)
      else $error("secondary stopped while kept");
   c_switch: cover property (up_cnt == 3'h7 && $changed(sys_clk_select));
   c_disabled: cover property (up_cnt == 3'h7 && clock_switch_monitor_cfg);
   c_sec_kept: cover property (secondary_osc_enable && osc_enable[3]);
endmodule // scs_ctrl_sva

bind scs_ctrl scs_ctrl_sva scs_ctrl_sva_inst (.clock, .resetn,
   .clock_switch_monitor_cfg, .primary_submode_cfg, .primary_submode,
   .watchdog_timer_en, .secondary_osc_enable, .osc_startup_timer_done,
   .pll_lock_in, .new_clk_in, .osc_enable, .sys_clk_select);

// ### scs_ctrl_tb_top.sv
// self-checking bench for the clock switch controller
`timescale 1ns/1ps
`include "scs_defs.svh"
module scs_ctrl_tb_top
   import scs_pkg::*;
;
   localparam logic [11:0] OSC = `SCS_ADDR_OSC;
   localparam logic [11:0] KEY = `SCS_ADDR_KEY;
   localparam logic [11:0] STAT = `SCS_ADDR_IRQ_STAT;
   localparam logic [11:0] MASK = `SCS_ADDR_IRQ_MASK;
   logic clock, resetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic clock_switch_monitor_cfg, watchdog_timer_en, secondary_osc_enable;
   logic osc_startup_timer_done, pll_lock_in, clock_fail_in, new_clk_in;
   logic [2:0] reset_source_cfg, sys_clk_select;
   logic [1:0] primary_submode_cfg, primary_submode;
   logic [1:0] div = 2'h0;
   logic err;
   scs_osc_s osc_enable;
   scs_src_e seq [5] = '{SCS_SRC_PRI_PLL, SCS_SRC_FAST, SCS_SRC_FAST_PLL,
      SCS_SRC_SEC, SCS_SRC_LOW_PWR};
   int failures, n_tests;
   scs_ctrl scs_ctrl_inst (.clock, .resetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .clock_switch_monitor_cfg, .reset_source_cfg, .primary_submode_cfg,
      .watchdog_timer_en, .secondary_osc_enable, .osc_startup_timer_done,
      .pll_lock_in, .clock_fail_in, .new_clk_in, .osc_enable,
      .sys_clk_select, .primary_submode, .irq);
   // system clock, 8 ns period
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // new source clock at a quarter of the system rate
   always @(posedge clock) div <= div + 2'h1;
   assign new_clk_in = div[1];
   // ****
   // tasks
   // ****
   // apb request held until pready is sampled high; release is separate
   task automatic xfer(input logic [11:0] a, input logic w,
         input logic [31:0] d, input logic [3:0] s);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) begin
         @(posedge clock);
      end
      rd = prdata;
      err = pslverr;
   endtask
   task automatic idle();
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t exp %h got %h", $time, e, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d, 4'hF);
      idle();
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] m,
         input logic [31:0] e);
      xfer(a, 1'b0, 32'h0, 4'h0);
      idle();
      chk(e, rd & m);
   endtask
   // back to back keys keep the osc write inside the window
   task automatic osc_wr(input logic [31:0] d, input logic [3:0] s);
      xfer(KEY, 1'b1, {24'h0, `SCS_KEY1}, 4'h1);
      xfer(KEY, 1'b1, {24'h0, `SCS_KEY2}, 4'h1);
      xfer(OSC, 1'b1, d, s);
      idle();
   endtask
   task automatic req_sw(input scs_src_e s);
      osc_wr(32'(s) << 8, 4'h2);
      osc_wr(32'h1, 4'h1);
      rdc(OSC, 32'h9, 32'h1);
   endtask
   // poll for the done event, then check status and clear it
   task automatic fin_sw(input scs_src_e s);
      int n = 0;
      rd = 32'h0;
      while (rd[`SCS_IRQ_DONE] !== 1'b1 && n < 80) begin
         n++;
         xfer(STAT, 1'b0, 32'h0, 4'h0);
         idle();
      end
      chk(32'h1, rd & 32'h3);
      chk(1'b1, irq);
      rdc(OSC, 32'h7001, 32'(s) << 12);
      chk(s, sys_clk_select);
      wr(STAT, 32'h3);
      chk(1'b0, irq);
   endtask
   task automatic rst(input scs_src_e s, input logic c);
      resetn <= 1'b0;
      reset_source_cfg <= s;
      clock_switch_monitor_cfg <= c;
      repeat (8) @(posedge clock);
      resetn <= 1'b1;
      repeat (2) @(posedge clock);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ****
   // tests
   // ****
   initial begin
      {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
      {osc_startup_timer_done, pll_lock_in, clock_fail_in} = '0;
      {secondary_osc_enable, failures, n_tests} = '0;
      watchdog_timer_en = 1'b1;
      primary_submode_cfg = 2'h2;
      resetn = 1'b0;
      rst(SCS_SRC_FAST, 1'b0);
      wr(MASK, 32'h3);
      rdc(OSC, 32'h7001, 32'h0);
      rdc(12'h010, 32'hFFFFFFFF, 32'h0);
      chk(1'b0, err);
      // select write without unlock must not land
      wr(OSC, 32'h200);
      rdc(OSC, 32'h700, 32'h0);
      osc_wr(32'h0, 4'h2);
      osc_wr(32'h1, 4'h1);
      rdc(OSC, 32'h1, 32'h0);
      rdc(STAT, 32'h3, 32'h2);
      chk(1'b1, irq);
      wr(MASK, 32'h0);
      chk(1'b0, irq);
      wr(STAT, 32'h3);
      wr(MASK, 32'h3);
      clock_fail_in <= 1'b1;
      repeat (4) @(posedge clock);
      clock_fail_in <= 1'b0;
      rdc(OSC, 32'h8, 32'h8);
      // crystal switch stalls until the startup timer expires
      req_sw(SCS_SRC_PRI);
      repeat (80) @(posedge clock);
      chk(SCS_SRC_FAST, sys_clk_select);
      osc_startup_timer_done <= 1'b1;
      fin_sw(SCS_SRC_PRI);
      chk(1'b0, osc_enable.fast_internal_rc);
      chk(primary_submode_cfg, primary_submode);
      pll_lock_in <= 1'b1;
      secondary_osc_enable <= 1'b1;
      // pll to pll step taken only through plain fast rc
      foreach (seq[i]) begin
         req_sw(seq[i]);
         fin_sw(seq[i]);
      end
      chk(1'b1, osc_enable.secondary_oscillator);
      chk(1'b1, osc_enable.low_power_rc);
      chk(32'h18, osc_enable);
      // switching disabled by strap
      rst(SCS_SRC_LOW_PWR, 1'b1);
      rdc(OSC, 32'h7000, 32'h5000);
      osc_wr(32'h200, 4'h2);
      osc_wr(32'h1, 4'h1);
      rdc(OSC, 32'h1, 32'h0);
      repeat (80) @(posedge clock);
      chk(SCS_SRC_LOW_PWR, sys_clk_select);
      end_sim();
   end
   // hang guard, far beyond the expected run
   initial begin
      repeat (30000) @(posedge clock);
      failures++;
      end_sim();
   end
endmodule // scs_ctrl_tb_top

// ### scs_defs.svh
// constants for the system clock switch controller
// ****************************************************************
// ****************************************************************
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// register byte addresses
`define SCS_ADDR_OSC 12'h000
`define SCS_ADDR_KEY 12'h004
`define SCS_ADDR_IRQ_STAT 12'h008
`define SCS_ADDR_IRQ_MASK 12'h00C
// osc_control_reg fields
`define SCS_BIT_REQ 0
`define SCS_BIT_FAIL 3
`define SCS_BIT_LOCK 5
`define SCS_NEW_LO 8
`define SCS_CUR_LO 12
// unlock keys and window length
`define SCS_KEY1 8'h46
`define SCS_KEY2 8'h57
`define SCS_WIN_CYC 4'h4
// new-clock cycles counted before the transfer
`define SCS_SETTLE_CYC 4'hA
// interrupt status bits
`define SCS_IRQ_DONE 0
`define SCS_IRQ_ABORT 1
`define SCS_IRQ_BITS 2

`endif

// ### scs_pkg.sv
// types for the system clock switch controller
package scs_pkg;
   // source codes held in the select and status fields
   typedef enum logic [2:0] {
      SCS_SRC_FAST = 3'b000,
      SCS_SRC_FAST_PLL = 3'b001,
      SCS_SRC_PRI = 3'b010,
      SCS_SRC_PRI_PLL = 3'b011,
      SCS_SRC_SEC = 3'b100,
      SCS_SRC_LOW_PWR = 3'b101,
      SCS_SRC_RSV6 = 3'b110,
      SCS_SRC_FAST_DIV = 3'b111
   } scs_src_e;

   // one bit for each physical oscillator
   typedef struct packed {
      logic low_power_rc;
      logic secondary_oscillator;
      logic primary_oscillator;
      logic fast_internal_rc;
      logic pll;
   } scs_osc_s;
endpackage

// ### scs_settle.sv
// counts new-clock cycles before the switchover
`timescale 1ns/1ps
module scs_settle #(
   parameter int CW = 4
) (
   input wire logic clock, // system clock
   input wire logic resetn, // async reset, active low
   input wire logic start, // begin a new count
   input wire logic new_clk_tick, // synchronised new clock edge pulse
   input wire logic [CW-1:0] target, // cycles to count
   output logic done // target reached, level until start
);
   logic [CW-1:0] cnt_reg;
   logic run_reg;

   // count edges of the new source while running
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= '0;
         run_reg <= 1'b0;
         done <= 1'b0;
      end else if (start) begin
         cnt_reg <= '0;
         run_reg <= 1'b1;
         done <= 1'b0;
      end else if (run_reg && new_clk_tick) begin
         if (cnt_reg == target - 1'b1) begin
            run_reg <= 1'b0;
            done <= 1'b1;
         end
         cnt_reg <= cnt_reg + 1'b1;
      end
   end
endmodule // scs_settle
